//--- design/sbr_pkg.sv
// constants, state encodings and timing figures of the system bus port
// assumes a single bus clock of 20 MHz driving every flip-flop
package sbr_pkg;

  // bus clock period
  localparam int CLK_PERIOD_NS = 50;

  // depth of the pin synchroniser
  localparam int SYNC_DEPTH = 2;

  // slave cycle: acknowledge to write capture and to size acknowledges, in bus clocks
  localparam int SLV_CAPTURE_BCLK = 2;
  localparam int SLV_SIZEACK_BCLK = 2;
  // slave cycle: acknowledge to ready output, in half bus clocks (2.5 clocks)
  localparam int SLV_SLAVE_READY_OUT_HALF_BCLK = 5;
  localparam int SLV_SLAVE_READY_OUT_CYC = (SLV_SLAVE_READY_OUT_HALF_BCLK + 1) / 2;
  localparam int SLV_CAPTURE_CYC = SLV_CAPTURE_BCLK;
  localparam int SLV_SIZEACK_CYC = SLV_SIZEACK_BCLK;
  localparam int SLV_CNT_W = 3;

  // width of the register data path and register address
  localparam int REG_DATA_W = 16;
  localparam int REG_ADDR_W = 6;

  // programmed wait count meaning no extra wait states
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_LAST = 2'h1;

  // reset values of the pin drivers (all strobes inactive high)
  localparam logic STROBE_IDLE = 1'h1;
  localparam logic OE_OFF = 1'h1;

  typedef enum logic [3:0] {
    M_IDLE = 4'h0,
    M_ARB = 4'h1,
    M_T1 = 4'h2,
    M_TW = 4'h3,
    M_T2 = 4'h4,
    M_END = 4'h5,
    M_TH = 4'h6,
    M_HOLDOFF = 4'h7
  } sbr_mstate_type;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_ACTIVE = 2'h1,
    S_RELEASE = 2'h2
  } sbr_sstate_type;

endpackage

//--- design/sbr_slave_if.sv
// signals between the bus port and its register slave engine
// assumes both ends run on the same bus clock
`timescale 1ns/1ps
interface sbr_slave_if;
  logic csAct;
  logic strobeAct;
  logic accessEnd;
  logic isRead;
  logic styleM;
  logic masterIdle;
  logic [sbr_pkg::REG_DATA_W-1:0] regRData;
  logic want;
  logic smackN;
  logic sizeAckN;
  logic rdyoN;
  logic drive;
  logic [sbr_pkg::REG_DATA_W-1:0] rdata;
  logic regWr;
  logic regRd;

  modport engine (
    input csAct, strobeAct, accessEnd, isRead, styleM, masterIdle, regRData,
    output want, smackN, sizeAckN, rdyoN, drive, rdata, regWr, regRd
  );
  modport port (
    output csAct, strobeAct, accessEnd, isRead, styleM, masterIdle, regRData,
    input want, smackN, sizeAckN, rdyoN, drive, rdata, regWr, regRd
  );
endinterface

//--- design/sbr_slave_engine.sv
// register slave engine: acknowledge, size acknowledge, ready and data timing
// assumes already synchronised chip select and strobe levels from the bus port
`timescale 1ns/1ps
module sbr_slave_engine (
  input wire logic clk,
  input wire logic rst_n,
  sbr_slave_if.engine slv
);

  sbr_pkg::sbr_sstate_type st_q;
  logic [sbr_pkg::SLV_CNT_W-1:0] cnt_q;
  logic read_q;

  wire startAcc = slv.csAct && slv.strobeAct && slv.masterIdle;
  wire hitCapture = (cnt_q == sbr_pkg::SLV_CAPTURE_CYC[sbr_pkg::SLV_CNT_W-1:0] - 3'h1);
  wire hitSizeAck = (cnt_q == sbr_pkg::SLV_SIZEACK_CYC[sbr_pkg::SLV_CNT_W-1:0] - 3'h1);
  wire hitRdyo = (cnt_q == sbr_pkg::SLV_SLAVE_READY_OUT_CYC[sbr_pkg::SLV_CNT_W-1:0] - 3'h1);
  wire cntFull = (cnt_q == 3'h7);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= sbr_pkg::S_IDLE;
      cnt_q <= 3'h0;
      read_q <= 1'h0;
      slv.want <= 1'h0;
      slv.smackN <= sbr_pkg::STROBE_IDLE;
      slv.sizeAckN <= sbr_pkg::STROBE_IDLE;
      slv.rdyoN <= sbr_pkg::STROBE_IDLE;
      slv.drive <= 1'h0;
      slv.rdata <= 16'h0000;
      slv.regWr <= 1'h0;
      slv.regRd <= 1'h0;
    end else begin
      // a pending chip select holds off new master cycles
      slv.want <= slv.csAct;
      slv.regWr <= 1'h0;
      slv.regRd <= 1'h0;
      case (st_q)
        sbr_pkg::S_IDLE: begin
          // each strobe opens its own access, even with chip select held
          if (startAcc) begin
            st_q <= sbr_pkg::S_ACTIVE;
            cnt_q <= 3'h0;
            read_q <= slv.isRead;
            slv.smackN <= 1'h0;
            slv.drive <= slv.isRead;
            slv.rdata <= slv.regRData;
            slv.regRd <= slv.isRead;
          end
        end
        sbr_pkg::S_ACTIVE: begin
          if (!cntFull) begin
            cnt_q <= cnt_q + 3'h1;
          end
          if (hitCapture && !read_q) begin
            slv.regWr <= 1'h1;
          end
          if (hitSizeAck && slv.styleM) begin
            slv.sizeAckN <= 1'h0;
          end
          if (hitRdyo && !slv.styleM) begin
            slv.rdyoN <= 1'h0;
          end
          if (slv.accessEnd) begin
            st_q <= sbr_pkg::S_RELEASE;
          end
        end
        sbr_pkg::S_RELEASE: begin
          // first of strobe or chip select going inactive ends the access
          st_q <= sbr_pkg::S_IDLE;
          slv.smackN <= sbr_pkg::STROBE_IDLE;
          slv.sizeAckN <= sbr_pkg::STROBE_IDLE;
          slv.rdyoN <= sbr_pkg::STROBE_IDLE;
          slv.drive <= 1'h0;
        end
        default: begin
          st_q <= sbr_pkg::S_IDLE;
        end
      endcase
    end
  end

endmodule

//--- design/sbr_bus_port.sv
// system bus port: asynchronous master memory cycle, bus retry, register slave
// assumes every bus pin arrives unsynchronised; user-side ports are on clk
`timescale 1ns/1ps
module sbr_bus_port (
  input wire logic clk,
  input wire logic rst_n,
  // user master request side
  input wire logic masterReq,
  input wire logic masterWrite,
  input wire logic [31:1] masterAddr,
  input wire logic [31:0] masterWData,
  output logic [31:0] masterRData,
  output logic masterDone,
  output logic masterBusy,
  // configuration and status bits
  input wire logic syncBusSelect,
  input wire logic extendedBusMode,
  input wire logic latchedRetryMode,
  input wire logic [1:0] waitCountField,
  input wire logic busStyleSelect,
  input wire logic retryFlagClear,
  output logic retryPendingFlag,
  // bus arbitration
  output logic busRequest,
  input wire logic busGrant,
  output logic busGrantAcknowledgeN,
  output logic busGrantAcknowledgeOeN,
  // master cycle pins
  output logic addressStrobeN,
  output logic earlyCycleStartN,
  output logic dataStrobeN,
  output logic masterWriteReadDir,
  output logic [31:1] addrOut,
  output logic masterOeN,
  input wire logic masterReadyInN,
  input wire logic busRetryInputN,
  // two-way data pins
  input wire logic [31:0] dataIn,
  output logic [31:0] dataOut,
  output logic dataOeN,
  // slave access pins
  input wire logic slaveAddressStrobe,
  input wire logic chipSelectN,
  input wire logic slaveReadWriteDir,
  input wire logic [5:0] registerAddress,
  output logic slaveMemoryAckN,
  output logic [1:0] sizeAcknowledgesN,
  output logic slaveReadyOutN,
  output logic slaveOeN,
  // register file side
  output logic [5:0] regAddr,
  output logic [15:0] regWData,
  output logic regWrite,
  output logic regRead,
  input wire logic [15:0] regRData
);

  localparam int SYNC_W = 44;

  sbr_slave_if slv ();

  function automatic logic isBusState(input sbr_pkg::sbr_mstate_type s);
    isBusState = (s == sbr_pkg::M_T1) || (s == sbr_pkg::M_TW) || (s == sbr_pkg::M_T2);
  endfunction

  // pin synchroniser: first stage feeds only the second
  logic [SYNC_W-1:0] syncMeta_q;
  logic [SYNC_W-1:0] syncPin_q;
  wire [SYNC_W-1:0] pinRaw = {masterReadyInN, busRetryInputN, chipSelectN,
    slaveAddressStrobe, slaveReadWriteDir, registerAddress, dataIn, busGrant};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncMeta_q <= {SYNC_W{1'h1}};
      syncPin_q <= {SYNC_W{1'h1}};
    end else begin
      syncMeta_q <= pinRaw;
      syncPin_q <= syncMeta_q;
    end
  end

  wire readyIn = !syncPin_q[43];
  wire retryIn = !syncPin_q[42];
  wire csIn = !syncPin_q[41];
  wire sasIn = syncPin_q[40];
  wire dirIn = syncPin_q[39];
  wire [5:0] raIn = syncPin_q[38:33];
  wire [31:0] dataSync = syncPin_q[32:1];
  wire grantIn = syncPin_q[0];

  // master cycle state
  sbr_pkg::sbr_mstate_type st_q;
  sbr_pkg::sbr_mstate_type stD;
  logic [31:1] addr_q;
  logic [31:0] wdata_q;
  logic wr_q;
  logic [1:0] waitLeft_q;
  logic hadWait_q;
  logic earlyRdy_q;
  logic retrySeen_q;
  logic flag_q;

  // asynchronous retry sampling only exists in extended asynchronous bus mode
  wire asyncRetry = extendedBusMode && !syncBusSelect;
  wire retryHit = retryIn || (asyncRetry && retrySeen_q);
  wire readyHit = readyIn || earlyRdy_q;
  wire inT2 = (st_q == sbr_pkg::M_T2);
  wire retryEnd = inT2 && retryHit;
  wire readyEnd = inT2 && !retryHit && readyHit;
  // a new attempt waits for the retry pin to be let go, so a held retry is not seen twice
  wire grantGo = grantIn && !retryIn;

  always_comb begin
    stD = st_q;
    case (st_q)
      sbr_pkg::M_IDLE: begin
        if (masterReq && !slv.want && !flag_q) begin
          stD = sbr_pkg::M_ARB;
        end
      end
      sbr_pkg::M_ARB: begin
        if (grantGo && !slv.want) begin
          stD = sbr_pkg::M_T1;
        end
      end
      sbr_pkg::M_T1: begin
        // programmed waits sit between first and second states
        if (waitCountField == sbr_pkg::WAIT_NONE) begin
          stD = sbr_pkg::M_T2;
        end else begin
          stD = sbr_pkg::M_TW;
        end
      end
      sbr_pkg::M_TW: begin
        if (waitLeft_q == sbr_pkg::WAIT_LAST) begin
          stD = sbr_pkg::M_T2;
        end
      end
      sbr_pkg::M_T2: begin
        // retry takes precedence over ready
        if (retryHit) begin
          stD = sbr_pkg::M_TH;
        end else if (readyHit) begin
          stD = sbr_pkg::M_END;
        end
      end
      sbr_pkg::M_END: begin
        stD = sbr_pkg::M_IDLE;
      end
      sbr_pkg::M_TH: begin
        if (latchedRetryMode) begin
          stD = sbr_pkg::M_HOLDOFF;
        end else begin
          stD = sbr_pkg::M_ARB;
        end
      end
      sbr_pkg::M_HOLDOFF: begin
        if (!flag_q && !retryIn) begin
          stD = sbr_pkg::M_ARB;
        end
      end
      default: begin
        stD = sbr_pkg::M_IDLE;
      end
    endcase
  end

  wire newCycle = (st_q == sbr_pkg::M_IDLE) && (stD == sbr_pkg::M_ARB);
  wire enterT1 = (stD == sbr_pkg::M_T1);
  wire busNow = isBusState(st_q);
  wire busNext = isBusState(stD);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= sbr_pkg::M_IDLE;
    end else begin
      st_q <= stD;
    end
  end

  // cycle attributes are latched once and held through retries
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_q <= 31'h00000000;
      wdata_q <= 32'h00000000;
      wr_q <= 1'h0;
    end else if (newCycle) begin
      addr_q <= masterAddr;
      wdata_q <= masterWData;
      wr_q <= masterWrite;
    end
  end

  wire [1:0] waitLeftD = (st_q == sbr_pkg::M_T1) ? waitCountField :
    (st_q == sbr_pkg::M_TW) ? waitLeft_q - 2'h1 : waitLeft_q;
  // early ready in the first state gives the short asynchronous cycle
  wire earlyRdyD = (st_q == sbr_pkg::M_T1) ?
    (!syncBusSelect && readyIn && waitCountField == sbr_pkg::WAIT_NONE) : earlyRdy_q;
  wire retrySeenD = enterT1 ? 1'h0 :
    busNow ? (retrySeen_q || (asyncRetry && retryIn)) : 1'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitLeft_q <= sbr_pkg::WAIT_NONE;
      hadWait_q <= 1'h0;
      earlyRdy_q <= 1'h0;
      retrySeen_q <= 1'h0;
    end else begin
      waitLeft_q <= waitLeftD;
      hadWait_q <= enterT1 ? 1'h0 : (hadWait_q || stD == sbr_pkg::M_TW);
      earlyRdy_q <= earlyRdyD;
      retrySeen_q <= retrySeenD;
    end
  end

  // retry flag: a retry in the clearing cycle still sets it
  wire flagSet = retryEnd && latchedRetryMode;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= 1'h0;
    end else if (flagSet) begin
      flag_q <= 1'h1;
    end else if (retryFlagClear) begin
      flag_q <= 1'h0;
    end
  end

  // master pin drive values
  wire dsOnD = busNext && (!wr_q || stD == sbr_pkg::M_TW ||
    (stD == sbr_pkg::M_T2 && hadWait_q));
  wire masterDriveD = busNext && wr_q;
  wire bgackOeD = busNext || busNow;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addressStrobeN <= sbr_pkg::STROBE_IDLE;
      earlyCycleStartN <= sbr_pkg::STROBE_IDLE;
      dataStrobeN <= sbr_pkg::STROBE_IDLE;
      masterWriteReadDir <= 1'h0;
      addrOut <= 31'h00000000;
      masterOeN <= sbr_pkg::OE_OFF;
    end else begin
      addressStrobeN <= !enterT1;
      earlyCycleStartN <= !enterT1;
      dataStrobeN <= !dsOnD;
      masterWriteReadDir <= wr_q;
      addrOut <= addr_q;
      masterOeN <= !busNext;
    end
  end

  // grant acknowledge driven high one cycle before floating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busRequest <= 1'h0;
      busGrantAcknowledgeN <= sbr_pkg::STROBE_IDLE;
      busGrantAcknowledgeOeN <= sbr_pkg::OE_OFF;
    end else begin
      busRequest <= busNext || (stD == sbr_pkg::M_ARB);
      busGrantAcknowledgeN <= !busNext;
      busGrantAcknowledgeOeN <= !bgackOeD;
    end
  end

  // read capture and completion report
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      masterRData <= 32'h00000000;
      masterDone <= 1'h0;
      masterBusy <= 1'h0;
      retryPendingFlag <= 1'h0;
    end else begin
      if (readyEnd && !wr_q) begin
        masterRData <= dataSync;
      end
      masterDone <= readyEnd;
      masterBusy <= (stD != sbr_pkg::M_IDLE);
      retryPendingFlag <= flag_q;
    end
  end

  // slave engine hookup; slave timing ignores the bus mode bit
  assign slv.csAct = csIn;
  assign slv.strobeAct = busStyleSelect ? !sasIn : sasIn;
  assign slv.accessEnd = !csIn || (busStyleSelect ? sasIn : !sasIn);
  assign slv.isRead = busStyleSelect ? dirIn : !dirIn;
  assign slv.styleM = busStyleSelect;
  // arbitration about to win counts as busy, so no slave start races a first state
  assign slv.masterIdle = (st_q == sbr_pkg::M_IDLE) || (st_q == sbr_pkg::M_HOLDOFF) ||
    (st_q == sbr_pkg::M_ARB && !grantGo);
  assign slv.regRData = regRData;

  sbr_slave_engine u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .slv(slv)
  );

  // shared data pins: slave read data only on the low half
  wire [31:0] dataOutD = slv.drive ? {16'h0000, slv.rdata} : wdata_q;
  wire dataDriveD = slv.drive || masterDriveD;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dataOut <= 32'h00000000;
      dataOeN <= sbr_pkg::OE_OFF;
    end else begin
      dataOut <= dataOutD;
      dataOeN <= !dataDriveD;
    end
  end

  // slave pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slaveMemoryAckN <= sbr_pkg::STROBE_IDLE;
      sizeAcknowledgesN <= 2'h3;
      slaveReadyOutN <= sbr_pkg::STROBE_IDLE;
      slaveOeN <= sbr_pkg::OE_OFF;
    end else begin
      slaveMemoryAckN <= slv.smackN;
      sizeAcknowledgesN <= {2{slv.sizeAckN}};
      slaveReadyOutN <= slv.rdyoN;
      slaveOeN <= slv.smackN;
    end
  end

  // register file strobes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regAddr <= 6'h00;
      regWData <= 16'h0000;
      regWrite <= 1'h0;
      regRead <= 1'h0;
    end else begin
      regAddr <= raIn;
      regWData <= dataSync[15:0];
      regWrite <= slv.regWr;
      regRead <= slv.regRd;
    end
  end

endmodule

//--- tb/sbr_bus_port_properties.sv
// pin-level timing properties of the system bus port
// assumes one bus clock and a synchronous active-low reset
`timescale 1ns/1ps
module sbr_bus_port_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] waitCountField,
  input wire logic busStyleSelect,
  input wire logic masterWriteReadDir,
  input wire logic addressStrobeN,
  input wire logic earlyCycleStartN,
  input wire logic dataStrobeN,
  input wire logic dataOeN,
  input wire logic [31:1] addrOut,
  input wire logic masterDone,
  input wire logic busGrantAcknowledgeN,
  input wire logic busGrantAcknowledgeOeN,
  input wire logic slaveMemoryAckN,
  input wire logic [1:0] sizeAcknowledgesN,
  input wire logic slaveReadyOutN,
  input wire logic regWrite
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_open;
    $fell(addressStrobeN) |-> $fell(earlyCycleStartN) ##1 addressStrobeN;
  endproperty
  a_open: assert property (p_open) else $error("cycle start strobes wrong");
  property p_addr;
    $fell(addressStrobeN) |=> ($stable(addrOut) && $stable(masterWriteReadDir))[*2];
  endproperty
  a_addr: assert property (p_addr) else $error("address moved in cycle");
  property p_rd;
    $fell(addressStrobeN) && !masterWriteReadDir |-> !dataStrobeN && dataOeN;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe late");
  property p_wr;
    $fell(addressStrobeN) && masterWriteReadDir && waitCountField == 2'h0
      |-> !dataOeN ##0 dataStrobeN[*3];
  endproperty
  a_wr: assert property (p_wr) else $error("zero wait write strobed");
  property p_dsend;
    $rose(dataStrobeN) |-> $rose(busGrantAcknowledgeN);
  endproperty
  a_dsend: assert property (p_dsend) else $error("data strobe end misplaced");
  property p_waits;
    $fell(addressStrobeN) && waitCountField == 2'h3 |-> !masterDone[*5];
  endproperty
  a_waits: assert property (p_waits) else $error("ended inside waits");
  property p_bus_grant_acknowledge;
    $rose(busGrantAcknowledgeN) |-> !busGrantAcknowledgeOeN ##1 busGrantAcknowledgeOeN;
  endproperty
  a_bus_grant_acknowledge: assert property (p_bus_grant_acknowledge) else $error("grant ack release wrong");
  property p_size;
    $fell(slaveMemoryAckN) && busStyleSelect
      |-> (sizeAcknowledgesN == 2'h3)[*2] ##1 sizeAcknowledgesN == 2'h0;
  endproperty
  a_size: assert property (p_size) else $error("size ack timing");
  property p_slave_ready_out;
    $fell(slaveMemoryAckN) && !busStyleSelect |-> slaveReadyOutN[*3] ##1 !slaveReadyOutN;
  endproperty
  a_slave_ready_out: assert property (p_slave_ready_out) else $error("ready out timing");
  property p_wcap;
    regWrite |-> !$past(slaveMemoryAckN, 2) && $past(slaveMemoryAckN, 3);
  endproperty
  a_wcap: assert property (p_wcap) else $error("write capture timing");
endmodule
bind sbr_bus_port sbr_bus_port_properties u_props (.clk, .rst_n, .waitCountField,
  .busStyleSelect, .masterWriteReadDir, .addressStrobeN, .earlyCycleStartN, .dataStrobeN,
  .dataOeN, .addrOut, .masterDone, .busGrantAcknowledgeN, .busGrantAcknowledgeOeN,
  .slaveMemoryAckN, .sizeAcknowledgesN, .slaveReadyOutN, .regWrite);

//--- tb/sbr_mem_model.sv
// memory and arbiter answering the port's master cycles
// assumes low-active ready and retry pins; retryMode 1 retries, 2 retries with ready
`timescale 1ns/1ps
module sbr_mem_model (
  input wire logic clk,
  input wire logic busRequest,
  input wire logic busGrantAcknowledgeN,
  input wire logic addressStrobeN,
  input wire logic masterWriteReadDir,
  input wire logic [31:1] addrOut,
  input wire logic [31:0] dataOut,
  input wire logic [2:0] readyDelay,
  input wire logic [1:0] retryMode,
  output logic busGrant,
  output logic masterReadyInN,
  output logic busRetryInputN,
  output logic [31:0] memData
);
  logic [31:0] mem [16];
  logic [31:0] flip;
  logic [3:0] idx;
  logic [2:0] cnt;
  logic active, drive, used, bgQ;
  // released data lines toggle so stale values never match
  assign memData = drive ? mem[idx] : flip;
  initial begin
    {busGrant, active, drive, used, bgQ} = 5'h0;
    {masterReadyInN, busRetryInputN} = 2'h3;
    flip = 32'h0;
    cnt = 3'h0;
    idx = 4'h0;
  end
  always @(posedge clk) begin
    busGrant <= busRequest;
    bgQ <= busGrantAcknowledgeN;
    flip <= ~flip;
    if (retryMode == 2'h0) used <= 1'b0;
    if (!active && !addressStrobeN) begin
      active <= 1'b1;
      cnt <= readyDelay;
      idx <= addrOut[5:2];
      drive <= !masterWriteReadDir;
    end else if (active && cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end else if (active && masterReadyInN && busRetryInputN) begin
      if (retryMode != 2'h0 && !used) begin
        busRetryInputN <= 1'b0;
        used <= 1'b1;
      end
      if (retryMode != 2'h1 || used) masterReadyInN <= 1'b0;
      if (masterWriteReadDir && (retryMode == 2'h0 || used)) mem[idx] <= dataOut;
    end
    if (active && busGrantAcknowledgeN && !bgQ) begin
      active <= 1'b0;
      drive <= 1'b0;
      {masterReadyInN, busRetryInputN} <= 2'h3;
    end
  end
endmodule

//--- tb/tb_top.sv
// self-checking bench: host register accesses and memory-backed master cycles
// assumes sbr_mem_model answers the master side
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n, masterReq, masterWrite, masterDone, masterBusy, syncBusSelect;
  logic extendedBusMode, latchedRetryMode, busStyleSelect, retryFlagClear, retryPendingFlag;
  logic busRequest, busGrant, busGrantAcknowledgeN, busGrantAcknowledgeOeN, addressStrobeN;
  logic earlyCycleStartN, dataStrobeN, masterWriteReadDir, masterOeN, masterReadyInN;
  logic busRetryInputN, dataOeN, slaveAddressStrobe, chipSelectN, slaveReadWriteDir;
  logic slaveMemoryAckN, slaveReadyOutN, slaveOeN, regWrite, regRead, hostDrive, adsQ;
  logic [1:0] waitCountField, sizeAcknowledgesN, retryMode;
  logic [2:0] readyDelay;
  logic [5:0] registerAddress, regAddr;
  logic [15:0] regWData, regRData, hostData, lastWD;
  logic [31:1] masterAddr, addrOut;
  logic [31:0] masterWData, masterRData, dataIn, dataOut, memData, rd;
  int num_errors = 0, checked = 0, starts = 0;
  assign dataIn = !dataOeN ? dataOut : hostDrive ? {16'h0, hostData} : memData;
  assign regRData = {10'h1a5, regAddr};
  always #25 clk = ~clk;
  always @(negedge clk) begin
    adsQ <= addressStrobeN;
    if (adsQ && !addressStrobeN) starts++;
    if (regWrite) lastWD <= regWData;
    if (!addressStrobeN) check(masterOeN, 32'h0);
  end
  sbr_bus_port u_dut (.*);
  sbr_mem_model u_mem (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic req(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    {masterWrite, masterAddr, masterWData, masterReq} = {wr, a[31:1], d, 1'b1};
    @(negedge clk);
    masterReq = 1'b0;
  endtask
  task automatic mdone;
    int n;
    n = 0;
    while (masterDone !== 1'b1 && n < 200) begin @(negedge clk); n++; end
    check(32'(n < 200), 1);
    while (masterBusy !== 1'b0 && n < 250) begin @(negedge clk); n++; end
    check(masterBusy, 32'h0);
    rd = masterRData;
  endtask
  task automatic sacc(input logic st, input logic wr, input logic [5:0] ra,
                      input logic [15:0] wd);
    int n;
    @(negedge clk);
    {busStyleSelect, slaveReadWriteDir, registerAddress} = {st, st ? !wr : wr, ra};
    {hostData, hostDrive, slaveAddressStrobe} = {wd, wr, !st};
    if (chipSelectN) begin
      @(negedge clk);
      chipSelectN = 1'b0;
    end
    n = 0;
    while (slaveMemoryAckN !== 1'b0 && n < 12) begin @(negedge clk); n++; end
    check(32'(n >= 3 && n <= 4), 1);
    check(regRead, !wr);
    if (!wr) check(dataIn, {16'h0, 10'h1a5, ra});
    n = 0;
    while ((st ? sizeAcknowledgesN !== 2'h0 : slaveReadyOutN !== 1'b0) && n < 9) begin
      @(negedge clk);
      n++;
    end
    check(n, st ? 2 : 3);
    {slaveAddressStrobe, hostDrive} = {st, 1'b0};
    n = 0;
    while (slaveMemoryAckN !== 1'b1 && n < 9) begin @(negedge clk); n++; end
    check({slaveOeN, sizeAcknowledgesN, slaveReadyOutN}, 32'hf);
    if (wr) check(lastWD, wd);
  endtask
  initial begin
    int b;
    {rst_n, masterReq, masterWrite, syncBusSelect, extendedBusMode, hostDrive} = 6'h0;
    {latchedRetryMode, busStyleSelect, retryFlagClear, slaveAddressStrobe} = 4'h0;
    {chipSelectN, slaveReadWriteDir, waitCountField, retryMode, readyDelay} = 9'h181;
    {registerAddress, hostData, masterAddr, masterWData} = '0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    for (int w = 0; w < 4; w++) begin
      waitCountField = w[1:0];
      readyDelay = 3'(w + 1);
      req(1'b1, 32'(4 * w), 32'h5a00_0000 + 32'(w));
      mdone;
      req(1'b0, 32'(4 * w), 32'h0);
      mdone;
      check(rd, 32'h5a00_0000 + 32'(w));
    end
    for (int e = 0; e < 3; e++) begin
      extendedBusMode = e[0];
      retryMode = (e == 2) ? 2'h2 : 2'h1;
      b = starts;
      req(1'b1, 32'h20, 32'hc3c3_0000 + 32'(e));
      mdone;
      retryMode = 2'h0;
      check(starts - b, 2);
      req(1'b0, 32'h20, 32'h0);
      mdone;
      check(rd, 32'hc3c3_0000 + 32'(e));
    end
    {extendedBusMode, latchedRetryMode, retryMode} = 4'h5;
    b = starts;
    req(1'b1, 32'h24, 32'h0f0f_0f0f);
    repeat (40) @(negedge clk);
    check({retryPendingFlag, 31'(starts - b)}, {1'b1, 31'h1});
    {retryMode, retryFlagClear} = 3'h1;
    @(negedge clk);
    retryFlagClear = 1'b0;
    mdone;
    check({retryPendingFlag, 31'(starts - b)}, {1'b0, 31'h2});
    latchedRetryMode = 1'b0;
    for (int s = 0; s < 4; s++) begin
      syncBusSelect = s[1];
      req(1'b0, 32'h0, 32'h0);
      mdone;
      check(rd, 32'h5a00_0000);
      sacc(s[0], 1'b1, 6'(9 + s), 16'h3c00 + 16'(s));
      sacc(s[0], 1'b0, 6'(9 + s), 16'h0);
      @(negedge clk);
      chipSelectN = 1'b1;
      repeat (2) @(negedge clk);
    end
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done;
  end
endmodule
